// ---- logic/mrs_pkg.sv ----
`default_nettype none
package mrs_pkg;
   // Clock and tick timing.
   localparam int unsigned CLK_PERIOD_NS  = 4;
   localparam int unsigned TICK_MS        = 100;
   localparam int unsigned TICK_CYCLES_DF = TICK_MS * 1000000 / CLK_PERIOD_NS;
   // Selector procedure windows, in seconds, and the slow flash in millihertz.
   localparam int unsigned HOLD_S         = 9;
   localparam int unsigned WINDOW_S       = 3;
   localparam int unsigned SLOW_FLASH_MHZ = 500;
   localparam int unsigned FAST_HALF_MS   = 200;
   localparam int unsigned SECOND_MS      = 1000;
   localparam logic [7:0]  HOLD_TICKS     = 8'(HOLD_S * 1000 / TICK_MS);
   localparam logic [7:0]  WINDOW_TICKS   = 8'(WINDOW_S * 1000 / TICK_MS);
   localparam logic [3:0]  SLOW_HALF_TICKS = 4'(1000000 / (2 * SLOW_FLASH_MHZ) / TICK_MS);
   localparam logic [3:0]  FAST_HALF_TICKS = 4'(FAST_HALF_MS / TICK_MS);
   localparam logic [3:0]  SECOND_TICKS   = 4'(SECOND_MS / TICK_MS);
   // Register byte offsets.
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_RETAIN     = 8'h04;
   localparam logic [7:0]  REG_NET        = 8'h08;
   localparam logic [7:0]  REG_STATUS     = 8'h0C;
   localparam logic [7:0]  REG_RUNTIME    = 8'h10;
   // Field positions.
   localparam int unsigned CTRL_FORCE_BIT = 0;
   localparam int unsigned NET_RATE_LSB   = 8;
   localparam int unsigned STAT_FMT_BIT   = 8;
   localparam int unsigned STAT_INV_BIT   = 9;
   localparam int unsigned STAT_CARD_BIT  = 10;
   localparam int unsigned STAT_OPER_BIT  = 11;
   // Reset values and bus response codes.
   localparam logic [15:0] RETAIN_RST     = 16'h0000;
   localparam logic [7:0]  NET_ADDR_RST   = 8'h02;
   localparam logic [3:0]  NET_RATE_RST   = 4'h0;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [3:0] {
      ST_BOOT, ST_NO_CARD, ST_MEMORY_RESET_POSITION_REQ, ST_HOLD, ST_STEADY, ST_REPRESS, ST_FORMAT, ST_MEM_RESET,
      ST_STOP, ST_RUN, ST_UPDATE, ST_BACKUP_ARM, ST_BACKUP_WAIT, ST_BACKUP
   } mrs_state_e;
endpackage : mrs_pkg
`default_nettype wire

// ---- logic/mrs_sequencer.sv ----
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
module mrs_sequencer #(
   parameter int unsigned TICK_CYCLES = mrs_pkg::TICK_CYCLES_DF
) (
   input  wire logic        MCLK,
   input  wire logic        ARST_N,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic        MEMORY_RESET_POSITION,
   input  wire logic        RUN_POSITION,
   input  wire logic        CARD_PRESENT,
   input  wire logic        CARD_USER_TYPE,
   input  wire logic        CARD_FORMATTED,
   input  wire logic        CARD_FAULT,
   input  wire logic        CARD_INVALID,
   input  wire logic        CARD_BLANK,
   input  wire logic        CARD_CAP_OK,
   input  wire logic        CARD_UPDATE_IMAGE,
   input  wire logic        UPDATE_STAMP,
   input  wire logic        POWER_FAIL,
   input  wire logic        LOAD_ACTIVE,
   input  wire logic        COPY_ACTIVE,
   input  wire logic        EVAL_FAULT,
   input  wire logic        FORMAT_FAULT,
   input  wire logic        OP_DONE,
   output logic             LED_STOP,
   output logic             LED_RUN,
   output logic             FORCE_INDICATOR,
   output logic             OPERATE_EN,
   output logic             FORMAT_REQ,
   output logic             UPDATE_REQ,
   output logic             BACKUP_REQ,
   output logic             MEM_RESET_PULSE,
   output logic             WARM_CLEAR,
   output logic [15:0]      RETAIN_MASK,
   output logic [7:0]       NET_ADDR,
   output logic [3:0]       NET_RATE,
   output logic             SAVE_WORK_REQ,
   output logic             MARK_INVALID
);
   import mrs_pkg::*;

   typedef struct packed {
      mrs_state_e  state;
      logic [31:0] tick_cnt;
      logic        tick;
      logic        samp_memory_reset_position;
      logic        samp_run;
      logic        memory_reset_position_db;
      logic        memory_reset_position_prev;
      logic        run_db;
      logic        card_prev;
      logic [7:0]  ph_cnt;
      logic [3:0]  slow_cnt;
      logic        slow;
      logic [3:0]  fast_cnt;
      logic        fast;
      logic        invalid;
      logic        save_work;
      logic        warm_clear;
      logic [3:0]  sec_cnt;
      logic [31:0] runtime;
      logic        force_en;
      logic [15:0] retain;
      logic [7:0]  net_addr;
      logic [3:0]  net_rate;
      logic        aw_full;
      logic [7:0]  awaddr;
      logic        w_full;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } mrs_regs_s;

   mrs_regs_s st_q;
   mrs_regs_s st_d;
   logic      format_need;
   logic      card_rise;
   logic      all_on;
   logic      arm;

   // Merges write data into a register under the byte strobes.
   function automatic logic [31:0] mrs_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction : mrs_merge

   assign format_need = !CARD_USER_TYPE || !CARD_FORMATTED || CARD_FAULT || CARD_INVALID
                        || st_q.invalid;
   assign card_rise   = CARD_PRESENT && !st_q.card_prev;

   always_comb begin
      logic [31:0] w;
      w = 32'h0000_0000;
      st_d = st_q;
      st_d.warm_clear = 1'b0;
      st_d.card_prev = CARD_PRESENT;
      st_d.memory_reset_position_prev = st_q.memory_reset_position_db;
      st_d.save_work = POWER_FAIL && CARD_PRESENT;

      // Fixed tick from the module clock; selector debounced on tick samples.
      st_d.tick = (st_q.tick_cnt == TICK_CYCLES - 1);
      st_d.tick_cnt = st_d.tick ? 32'h0000_0000 : st_q.tick_cnt + 32'h0000_0001;
      if (st_q.tick) begin
         st_d.samp_memory_reset_position = MEMORY_RESET_POSITION;
         st_d.samp_run = RUN_POSITION;
         if (MEMORY_RESET_POSITION == st_q.samp_memory_reset_position) begin
            st_d.memory_reset_position_db = MEMORY_RESET_POSITION;
         end
         if (RUN_POSITION == st_q.samp_run) begin
            st_d.run_db = RUN_POSITION;
         end
         st_d.ph_cnt = st_q.ph_cnt + 8'h01;
         if (st_q.slow_cnt == SLOW_HALF_TICKS - 4'h1) begin
            st_d.slow_cnt = 4'h0;
            st_d.slow = !st_q.slow;
         end else begin
            st_d.slow_cnt = st_q.slow_cnt + 4'h1;
         end
         if (st_q.fast_cnt == FAST_HALF_TICKS - 4'h1) begin
            st_d.fast_cnt = 4'h0;
            st_d.fast = !st_q.fast;
         end else begin
            st_d.fast_cnt = st_q.fast_cnt + 4'h1;
         end
         if (st_q.state == ST_RUN) begin
            if (st_q.sec_cnt == SECOND_TICKS - 4'h1) begin
               st_d.sec_cnt = 4'h0;
               st_d.runtime = st_q.runtime + 32'h0000_0001;
            end else begin
               st_d.sec_cnt = st_q.sec_cnt + 4'h1;
            end
         end
      end

      if (!CARD_PRESENT) begin
         st_d.state = ST_NO_CARD;
      end else if (card_rise && st_q.state != ST_BOOT) begin
         st_d.state = ST_MEMORY_RESET_POSITION_REQ;
      end else begin
         case (st_q.state)
            ST_BOOT: begin
               if (CARD_UPDATE_IMAGE && CARD_CAP_OK) begin
                  st_d.state = ST_UPDATE;
               end else if (MEMORY_RESET_POSITION && CARD_BLANK && CARD_CAP_OK) begin
                  st_d.state = ST_BACKUP_ARM;
                  st_d.samp_memory_reset_position = 1'b1;
                  st_d.memory_reset_position_db = 1'b1;
               end else if (UPDATE_STAMP) begin
                  st_d.state = ST_MEM_RESET;
               end else if (format_need) begin
                  st_d.state = ST_MEMORY_RESET_POSITION_REQ;
               end else begin
                  st_d.state = ST_STOP;
               end
            end
            ST_MEMORY_RESET_POSITION_REQ: begin
               if (st_q.memory_reset_position_db) begin
                  st_d.state = format_need ? ST_HOLD : ST_MEM_RESET;
               end
            end
            ST_HOLD: begin
               if (!st_q.memory_reset_position_db) begin
                  st_d.state = ST_MEMORY_RESET_POSITION_REQ;
               end else if (st_q.tick && st_q.ph_cnt == HOLD_TICKS - 8'h01) begin
                  st_d.state = ST_STEADY;
               end
            end
            ST_STEADY: begin
               if (!st_q.memory_reset_position_db) begin
                  st_d.state = ST_REPRESS;
               end else if (st_q.tick && st_q.ph_cnt == WINDOW_TICKS - 8'h01) begin
                  st_d.state = ST_MEMORY_RESET_POSITION_REQ;
               end
            end
            ST_REPRESS: begin
               if (st_q.memory_reset_position_db) begin
                  st_d.state = ST_FORMAT;
               end else if (st_q.tick && st_q.ph_cnt == WINDOW_TICKS - 8'h01) begin
                  st_d.state = ST_MEMORY_RESET_POSITION_REQ;
               end
            end
            ST_FORMAT: begin
               if (FORMAT_FAULT) begin
                  st_d.state = ST_MEM_RESET;
               end else if (OP_DONE) begin
                  st_d.invalid = 1'b0;
                  st_d.state = ST_MEM_RESET;
               end
            end
            ST_MEM_RESET: begin
               st_d.state = format_need ? ST_MEMORY_RESET_POSITION_REQ : ST_STOP;
            end
            ST_STOP: begin
               // Only a fresh press requests a reset, so one press gives one memory reset.
               if (st_q.memory_reset_position_db && !st_q.memory_reset_position_prev) begin
                  st_d.state = ST_MEMORY_RESET_POSITION_REQ;
               end else if (st_q.run_db && !format_need) begin
                  st_d.state = ST_RUN;
                  st_d.warm_clear = 1'b1;
               end
            end
            ST_RUN: begin
               if (!st_q.run_db) begin
                  st_d.state = ST_STOP;
               end
            end
            ST_UPDATE: begin
               if (OP_DONE) begin
                  st_d.state = ST_MEMORY_RESET_POSITION_REQ;
               end
            end
            ST_BACKUP_ARM: begin
               if (!st_q.memory_reset_position_db) begin
                  st_d.state = ST_BACKUP_WAIT;
               end
            end
            ST_BACKUP_WAIT: begin
               if (st_q.memory_reset_position_db) begin
                  st_d.state = ST_BACKUP;
               end
            end
            ST_BACKUP: begin
               if (OP_DONE) begin
                  st_d.state = ST_MEMORY_RESET_POSITION_REQ;
               end
            end
            ST_NO_CARD: begin
               st_d.state = ST_NO_CARD;
            end
            default: begin
               st_d.state = ST_BOOT;
            end
         endcase
      end
      // The response window runs on from the steady indication across the release.
      if (st_d.state != st_q.state && !(st_q.state == ST_STEADY && st_d.state == ST_REPRESS)) begin
         st_d.ph_cnt = 8'h00;
      end

      // A marking event wins over the clear at format completion.
      if ((POWER_FAIL && (LOAD_ACTIVE || COPY_ACTIVE)) || EVAL_FAULT
          || (st_q.state == ST_FORMAT && FORMAT_FAULT)) begin
         st_d.invalid = 1'b1;
      end

      // Register write path: address and data are held until both are present.
      if (S_AXI_AWVALID && !st_q.aw_full) begin
         st_d.aw_full = 1'b1;
         st_d.awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !st_q.w_full) begin
         st_d.w_full = 1'b1;
         st_d.wdata = S_AXI_WDATA;
         st_d.wstrb = S_AXI_WSTRB;
      end
      if (st_q.aw_full && st_q.w_full && !st_q.bvalid) begin
         st_d.aw_full = 1'b0;
         st_d.w_full = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = RESP_OKAY;
         case (st_q.awaddr)
            REG_CTRL: begin
               w = mrs_merge({31'h0, st_q.force_en}, st_q.wdata, st_q.wstrb);
               st_d.force_en = w[CTRL_FORCE_BIT];
            end
            REG_RETAIN: begin
               w = mrs_merge({16'h0000, st_q.retain}, st_q.wdata, st_q.wstrb);
               st_d.retain = w[15:0];
            end
            REG_NET: begin
               w = mrs_merge({20'h00000, st_q.net_rate, st_q.net_addr}, st_q.wdata, st_q.wstrb);
               st_d.net_addr = w[7:0];
               st_d.net_rate = w[NET_RATE_LSB +: 4];
            end
            REG_STATUS, REG_RUNTIME: begin
               st_d.bresp = RESP_OKAY;
            end
            default: begin
               st_d.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (st_q.bvalid && S_AXI_BREADY) begin
         st_d.bvalid = 1'b0;
      end

      // Register read path.
      if (S_AXI_ARVALID && !st_q.rvalid) begin
         st_d.rvalid = 1'b1;
         st_d.rresp = RESP_OKAY;
         st_d.rdata = 32'h0000_0000;
         case (S_AXI_ARADDR)
            REG_CTRL:    st_d.rdata[CTRL_FORCE_BIT] = st_q.force_en;
            REG_RETAIN:  st_d.rdata[15:0] = st_q.retain;
            REG_NET:     st_d.rdata[11:0] = {st_q.net_rate, st_q.net_addr};
            REG_STATUS: begin
               st_d.rdata[3:0] = st_q.state;
               st_d.rdata[STAT_FMT_BIT] = format_need;
               st_d.rdata[STAT_INV_BIT] = st_q.invalid;
               st_d.rdata[STAT_CARD_BIT] = CARD_PRESENT;
               st_d.rdata[STAT_OPER_BIT] = (st_q.state == ST_RUN);
            end
            REG_RUNTIME: st_d.rdata = st_q.runtime;
            default:     st_d.rresp = RESP_SLVERR;
         endcase
      end else if (st_q.rvalid && S_AXI_RREADY) begin
         st_d.rvalid = 1'b0;
      end
   end

   // Network settings and runtime return to their reset values (address 8'h02, rate and runtime zero) on power-on reset only, never on a memory reset.
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_q <= '{state: ST_BOOT, retain: RETAIN_RST, net_addr: NET_ADDR_RST,
                   net_rate: NET_RATE_RST, default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   assign S_AXI_AWREADY = !st_q.aw_full;
   assign S_AXI_WREADY  = !st_q.w_full;
   assign S_AXI_BVALID  = st_q.bvalid;
   assign S_AXI_BRESP   = st_q.bresp;
   assign S_AXI_ARREADY = !st_q.rvalid;
   assign S_AXI_RVALID  = st_q.rvalid;
   assign S_AXI_RDATA   = st_q.rdata;
   assign S_AXI_RRESP   = st_q.rresp;

   assign all_on          = (st_q.state == ST_UPDATE) || (st_q.state == ST_BACKUP);
   assign arm             = (st_q.state == ST_BACKUP_ARM) || (st_q.state == ST_BACKUP_WAIT);
   assign LED_STOP        = (st_q.state == ST_MEMORY_RESET_POSITION_REQ || st_q.state == ST_HOLD || arm) ? st_q.slow
                            : (st_q.state == ST_FORMAT) ? st_q.fast
                            : (st_q.state != ST_RUN);
   assign LED_RUN         = all_on || (st_q.state == ST_RUN) || (arm && st_q.slow);
   assign FORCE_INDICATOR = all_on || (arm ? st_q.slow : st_q.force_en);
   assign OPERATE_EN      = (st_q.state == ST_RUN);
   assign FORMAT_REQ      = (st_q.state == ST_FORMAT);
   assign UPDATE_REQ      = (st_q.state == ST_UPDATE);
   assign BACKUP_REQ      = (st_q.state == ST_BACKUP);
   // A memory reset clears working memory only; the card program is never erased here.
   assign MEM_RESET_PULSE = (st_q.state == ST_MEM_RESET);
   assign WARM_CLEAR      = st_q.warm_clear;
   assign RETAIN_MASK     = st_q.retain;
   assign NET_ADDR        = st_q.net_addr;
   assign NET_RATE        = st_q.net_rate;
   assign SAVE_WORK_REQ   = st_q.save_work;
   assign MARK_INVALID    = st_q.invalid;

   a_repeat_request: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (st_q.state == ST_MEM_RESET && format_need && CARD_PRESENT) |=> st_q.state == ST_MEMORY_RESET_POSITION_REQ)
      else $error("memory reset did not renew the request");
   a_invalid_mark: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (POWER_FAIL && (LOAD_ACTIVE || COPY_ACTIVE)) |=> MARK_INVALID)
      else $error("interrupted load did not mark content invalid");
   a_format_only: assert property (@(posedge MCLK) disable iff (!ARST_N)
      FORMAT_REQ |-> $past(st_q.state) inside {ST_REPRESS, ST_FORMAT})
      else $error("format requested outside the procedure");
   a_request_flash: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (st_q.state == ST_MEMORY_RESET_POSITION_REQ && $past(st_q.state) == ST_MEMORY_RESET_POSITION_REQ && $past(st_q.tick)
       && $past(st_q.slow_cnt) == SLOW_HALF_TICKS - 4'h1) |-> LED_STOP != $past(LED_STOP))
      else $error("stop indicator did not toggle on schedule");
   a_hold_steady: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (st_q.state == ST_HOLD && st_q.memory_reset_position_db && CARD_PRESENT && st_q.tick
       && st_q.ph_cnt == HOLD_TICKS - 8'h01) |=> (st_q.state == ST_STEADY && LED_STOP))
      else $error("hold did not give a steady stop indicator");
   a_window_miss: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (st_q.state == ST_REPRESS && !st_q.memory_reset_position_db && CARD_PRESENT && st_q.tick
       && st_q.ph_cnt == WINDOW_TICKS - 8'h01) |=> st_q.state == ST_MEMORY_RESET_POSITION_REQ)
      else $error("missed window did not return to request");
   a_std_reset: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (st_q.state == ST_MEMORY_RESET_POSITION_REQ && st_q.memory_reset_position_db && !format_need && CARD_PRESENT && !card_rise)
      |=> MEM_RESET_PULSE ##1 (!MEM_RESET_PULSE && !FORMAT_REQ))
      else $error("standard memory reset misbehaved");
   a_new_card: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (card_rise && st_q.state != ST_BOOT) |=> st_q.state == ST_MEMORY_RESET_POSITION_REQ)
      else $error("new card did not request memory reset");
   a_no_card: assert property (@(posedge MCLK) disable iff (!ARST_N)
      !CARD_PRESENT |=> !OPERATE_EN)
      else $error("operation allowed without a card");
   a_save_work: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (POWER_FAIL && CARD_PRESENT) |=> SAVE_WORK_REQ)
      else $error("working memory save not requested");
endmodule : mrs_sequencer
`default_nettype wire

// ---- bench/mrs_card_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module mrs_card_model (
   input  wire logic       mclk,
   input  wire logic       arst_n,
   input  wire logic       want_card,
   input  wire logic [1:0] kind,
   input  wire logic       operate_en,
   input  wire logic       format_req,
   output logic            card_present,
   output logic            card_formatted,
   output logic            card_blank,
   output logic            card_cap_ok,
   output logic            card_update_image,
   output logic            op_done
);
   logic       fmt_q;
   logic [5:0] busy_q;
   assign card_formatted    = card_present & fmt_q;
   assign card_blank        = card_present & (kind == 2'h3);
   assign card_update_image = card_present & (kind == 2'h2);
   assign card_cap_ok       = card_present & kind[1];
   assign op_done           = format_req & (busy_q == 6'h30);
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         card_present <= 1'h1;
         fmt_q        <= 1'h1;
         busy_q       <= 6'h00;
      end else begin
         if (!operate_en)
            card_present <= want_card;
         if (!operate_en && want_card && !card_present)
            fmt_q <= (kind == 2'h0);
         else if (op_done)
            fmt_q <= 1'h1;
         busy_q <= format_req ? busy_q + 6'h01 : 6'h00;
      end
   end
endmodule : mrs_card_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import mrs_pkg::*;
   localparam int unsigned TK = 4;
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic [7:0]  awa = 8'h00;
   logic [7:0]  ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [3:0]  ws = 4'hF;
   logic        awv = 1'h0;
   logic        wv = 1'h0;
   logic        arv = 1'h0;
   logic        rdy = 1'h0;
   logic        sel_rst = 1'h0;
   logic        run = 1'h0;
   logic        ins = 1'h1;
   logic        pf = 1'h0;
   logic        ld = 1'h0;
   logic [1:0]  kind = 2'h0;
   logic [31:0] d;
   logic [1:0]  r;
   int          err_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          n;
   int          mrp = 0;
   int          wcp = 0;
   wire logic        awr, wr, bv, arr, rv, led_s, op_en, fmt_rq, mrp_o, wc, sv, inv, cp, cf, cb, cc, cu, od;
   wire logic        led_r, frc;
   wire logic [1:0]  br, rr;
   wire logic [31:0] rd;
   wire logic [15:0] rm;
   wire logic [7:0]  na;
   wire logic [3:0]  nr;
   mrs_sequencer #(.TICK_CYCLES(TK)) dut_u (.MCLK(clk), .ARST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
      .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(rdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rdy),
      .MEMORY_RESET_POSITION(sel_rst), .RUN_POSITION(run), .CARD_PRESENT(cp), .CARD_USER_TYPE(cp),
      .CARD_FORMATTED(cf), .CARD_FAULT(1'h0), .CARD_INVALID(1'h0), .CARD_BLANK(cb), .CARD_CAP_OK(cc),
      .CARD_UPDATE_IMAGE(cu), .UPDATE_STAMP(1'h0), .POWER_FAIL(pf), .LOAD_ACTIVE(ld), .COPY_ACTIVE(ld),
      .EVAL_FAULT(1'h0), .FORMAT_FAULT(1'h0), .OP_DONE(od), .LED_STOP(led_s), .LED_RUN(led_r), .FORCE_INDICATOR(frc),
      .OPERATE_EN(op_en), .FORMAT_REQ(fmt_rq), .UPDATE_REQ(), .BACKUP_REQ(), .MEM_RESET_PULSE(mrp_o),
      .WARM_CLEAR(wc), .RETAIN_MASK(rm), .NET_ADDR(na), .NET_RATE(nr), .SAVE_WORK_REQ(sv), .MARK_INVALID(inv));
   mrs_card_model card_u (.mclk(clk), .arst_n(rst_n), .want_card(ins), .kind(kind), .operate_en(op_en),
      .format_req(fmt_rq), .card_present(cp), .card_formatted(cf), .card_blank(cb), .card_cap_ok(cc),
      .card_update_image(cu), .op_done(od));
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr32(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      awa <= a;
      wd <= v;
      awv <= 1'h1;
      wv <= 1'h1;
      forever begin
         #1;
         ta = awv & awr;
         tw = wv & wr;
         tb = bv;
         r = br;
         @(posedge clk);
         if (ta)
            awv <= 1'h0;
         if (tw)
            wv <= 1'h0;
         if (tb)
            break;
      end
   endtask : wr32
   task automatic rd32(input logic [7:0] a);
      logic ta, tr;
      ara <= a;
      arv <= 1'h1;
      forever begin
         #1;
         ta = arv & arr;
         tr = rv;
         d = rd;
         r = rr;
         @(posedge clk);
         if (ta)
            arv <= 1'h0;
         if (tr)
            break;
      end
   endtask : rd32
   // Polls the state code until it matches or the read budget runs out.
   task automatic wst(input logic [3:0] s, input int lim);
      for (int i = 0; i < lim; i++) begin
         rd32(REG_STATUS);
         if (d[3:0] === s)
            break;
      end
      chk(32'(d[3:0]), 32'(s));
   endtask : wst
   task automatic gap(output int k);
      logic v;
      #1;
      v = led_s;
      k = 0;
      while (led_s === v && k < 200) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask : gap
   initial forever #2 clk = ~clk;
   always @(negedge clk) begin
      cyc++;
      if (mrp_o)
         mrp++;
      if (wc)
         wcp++;
      if (cyc == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      rdy <= 1'h1;
      @(posedge clk);
      wst(4'h8, 20);
      rd32(REG_RETAIN);
      chk(d, 32'h0);
      rd32(REG_NET);
      chk(d, 32'h2);
      wr32(REG_NET, 32'h0A35);
      wr32(REG_RETAIN, 32'h1234);
      rd32(8'h20);
      chk(32'(r), 32'(RESP_SLVERR));
      chk(32'(na), 32'h35);
      chk(32'(nr), 32'hA);
      chk(32'(rm), 32'h1234);
      wr32(REG_CTRL, 32'h1);
      chk(32'(r), 32'(RESP_OKAY));
      chk(32'(frc), 32'h1);
      run <= 1'h1;
      wst(4'h9, 20);
      chk(32'(led_r), 32'h1);
      chk(32'(wcp), 32'h1);
      ins <= 1'h0;
      repeat (20) @(posedge clk);
      rd32(REG_STATUS);
      chk(32'(d[STAT_CARD_BIT]), 32'h1);
      run <= 1'h0;
      wst(4'h1, 20);
      run <= 1'h1;
      repeat (40) @(posedge clk);
      wst(4'h1, 2);
      chk(32'(op_en), 32'h0);
      run <= 1'h0;
      ins <= 1'h1;
      wst(4'h2, 20);
      gap(n);
      gap(n);
      chk(32'(n), 32'(SLOW_HALF_TICKS * TK));
      @(posedge clk);
      sel_rst <= 1'h1;
      repeat (3 * TK) @(posedge clk);
      sel_rst <= 1'h0;
      wst(4'h8, 40);
      chk(32'(mrp), 32'h1);
      chk(32'(na), 32'h35);
      ins <= 1'h0;
      wst(4'h1, 20);
      kind <= 2'h1;
      ins <= 1'h1;
      wst(4'h2, 20);
      chk(32'(d[STAT_FMT_BIT]), 32'h1);
      sel_rst <= 1'h1;
      wst(4'h4, 200);
      chk(32'(led_s), 32'h1);
      chk(32'(fmt_rq), 32'h0);
      sel_rst <= 1'h0;
      wst(4'h5, 20);
      wst(4'h2, 100);
      sel_rst <= 1'h1;
      wst(4'h4, 200);
      sel_rst <= 1'h0;
      wst(4'h5, 20);
      sel_rst <= 1'h1;
      wst(4'h6, 20);
      chk(32'(fmt_rq), 32'h1);
      sel_rst <= 1'h0;
      wst(4'h8, 60);
      ld <= 1'h1;
      pf <= 1'h1;
      repeat (3) @(posedge clk);
      chk(32'(sv), 32'h1);
      chk(32'(inv), 32'h1);
      pf <= 1'h0;
      ld <= 1'h0;
      rd32(REG_STATUS);
      chk(32'(d[STAT_FMT_BIT]), 32'h1);
      kind <= 2'h2;
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      wst(4'hA, 4);
      chk(32'({led_s, led_r, frc}), 32'h7);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
